// File: bench/cid_contacts.sv
// field contacts: a closed contact applies its source voltage code
`timescale 1ns/1ps
`default_nettype none
module cid_contacts (
  input  wire logic [15:0]  closed,
  input  wire logic [127:0] source,
  output var  logic [127:0] contact_voltage
);
  // an open wet contact carries no voltage
  always_comb begin
    for (int k = 0; k < 16; k++)
      contact_voltage[k*8 +: 8] = closed[k] ? source[k*8 +: 8] : 8'h00;
  end
endmodule // cid_contacts
`default_nettype wire

// File: bench/cid_debouncer_sva.sv
// port assertions for the contact input debouncer
`timescale 1ns/1ps
`default_nettype none
module cid_chk #(
  parameter SCAN_CYCLES = 20
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [3:0]  module_present,
  input wire logic        pass_start,
  input wire logic [15:0] input_closed_flag,
  input wire logic        event_valid,
  input wire logic        event_ready,
  input wire logic [3:0]  event_index,
  input wire logic [31:0] event_time_us
);
  wire [15:0] pm = {{4{module_present[3]}}, {4{module_present[2]}}, {4{module_present[1]}}, {4{module_present[0]}}};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_RESP: assert property (s_wr |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_RD_RESP: assert property (s_rd |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_FLAG_AT_PASS: assert property ($changed(input_closed_flag) |-> $past(pass_start))
    else $error("flag moved outside pass start");
  AST_FLAG_PRESENT: assert property ((input_closed_flag & ~pm) == 16'h0000)
    else $error("absent input flagged");
  AST_EVENT_PRESENT: assert property (event_valid |-> pm[event_index])
    else $error("event for absent input");
  AST_EVENT_HOLDS: assert property (event_valid && !event_ready |=> event_valid && $stable(event_index) && $stable(event_time_us))
    else $error("event dropped or changed");
endmodule // cid_chk
bind cid_debouncer cid_chk #(.SCAN_CYCLES(SCAN_CYCLES)) chk (.*);
`default_nettype wire

// File: bench/cid_debouncer_test.sv
// self-checking bench for the contact input debouncer
`timescale 1ns/1ps
`default_nettype none
`include "cid_map.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; $display("mismatch %0t: got %h want %h", $time, a, e); end end
module cid_debouncer_test;
  logic         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pass_start = 1'b0, event_ready = 1'b0;
  logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0, d, t, t0, tus;
  logic [3:0]   s_axi_wstrb = 4'hF, module_present = 4'h7, i;
  logic [15:0]  closed = 16'h0000;
  // volts per input: input 4 just under, input 5 at the group threshold
  logic [127:0] source = {{10{8'h30}}, 8'h21, 8'h20, {4{8'h30}}};
  logic [1:0]   r;
  logic         c;
  wire          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, event_valid, event_closed;
  wire [1:0]    s_axi_bresp, s_axi_rresp;
  wire [31:0]   s_axi_rdata, event_time_us;
  wire [15:0]   input_closed_flag;
  wire [3:0]    event_index;
  wire [127:0]  contact_voltage;
  int           err_count = 0, n_tests = 0, cyc = 0;
  cid_debouncer #(.SCAN_CYCLES(100)) uut (.*);
  cid_contacts far (.*);
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= aresetn ? cyc + 1 : 0;
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    `CHK(d, e);
  endtask
  task automatic ev;
    @(posedge aclk);
    event_ready <= 1'b1;
    do @(posedge aclk); while (!event_valid);
    i = event_index;
    c = event_closed;
    t = event_time_us;
    event_ready <= 1'b0;
  endtask
  task automatic pass_pulse;
    @(posedge aclk);
    pass_start <= 1'b1;
    @(posedge aclk);
    pass_start <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #200us;
    err_count++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(`CID_OFF_INTERVAL, 32'h4);
    rchk(`CID_OFF_THRESHOLD, 32'h00111111);
    rchk(`CID_OFF_PRESENT, 32'h00000FFF);
    rd(8'h20, d, r);
    `CHK(r, `CID_RESP_SLVERR);
    wr(`CID_OFF_PRESENT, 32'h0, r);
    `CHK(r, `CID_RESP_OKAY);
    rchk(`CID_OFF_PRESENT, 32'h00000FFF);
    wr(`CID_OFF_INTERVAL, 32'h5, r);
    rchk(`CID_OFF_INTERVAL, 32'h5);
    wr(`CID_OFF_THRESHOLD, 32'hA6542111, r);
    rchk(`CID_OFF_THRESHOLD, 32'h00542111);
    wr(`CID_OFF_EVENT_EN, 32'h1021, r);
    rchk(`CID_OFF_EVENT_EN, 32'h21);
    closed <= 16'h1033;
    tus = cyc / 100;
    ev;
    `CHK({i, c}, 5'h01);
    `CHK(t + 1 - tus <= 3, 1'b1);
    t0 = t;
    ev;
    `CHK({i, c, t}, {5'h0B, t0});
    `CHK(input_closed_flag, 16'h0000);
    rchk(`CID_OFF_VALIDATED, 32'h23);
    pass_pulse;
    `CHK(input_closed_flag, 16'h0023);
    repeat (300) @(posedge aclk);
    `CHK(event_valid, 1'b0);
    closed <= 16'h1032;
    repeat (300) @(posedge aclk);
    closed <= 16'h1033;
    repeat (400) @(posedge aclk);
    closed <= 16'h1032;
    tus = cyc / 100;
    ev;
    `CHK({i, c}, 5'h00);
    `CHK(t + 1 - tus <= 3, 1'b1);
    `CHK(input_closed_flag, 16'h0023);
    pass_pulse;
    `CHK(input_closed_flag, 16'h0022);
    end_of_test;
  end
endmodule // cid_debouncer_test
`default_nettype wire

// File: logic/cid_debouncer.v
// contact input debouncer: scan, threshold, debounce, timestamp, events, pass update, axi4-lite registers
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "cid_map.vh"

module cid_debouncer #(
  parameter SCAN_CYCLES = `CID_SCAN_US * `CID_CLK_MHZ
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [7:0]   s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output reg          s_axi_awready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output reg          s_axi_wready,
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  input  wire [7:0]   s_axi_araddr,
  input  wire         s_axi_arvalid,
  output reg          s_axi_arready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  input  wire [127:0] contact_voltage,
  input  wire [3:0]   module_present,
  input  wire         pass_start,
  output reg  [15:0]  input_closed_flag,
  output reg          event_valid,
  input  wire         event_ready,
  output reg  [3:0]   event_index,
  output reg          event_closed,
  output reg  [31:0]  event_time_us
);

  localparam US_CYCLES = (`CID_US_NS + `CID_CLK_NS - 1) / `CID_CLK_NS;
  localparam integer SCAN_LAST_FULL = SCAN_CYCLES - 1;
  localparam integer US_LAST_FULL   = US_CYCLES - 1;
  localparam [16:0]  SCAN_LAST      = SCAN_LAST_FULL[16:0];
  localparam [6:0]   US_LAST        = US_LAST_FULL[6:0];

  // byte-lane merge of a write into a register word
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer b;
    begin
      wmerge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          wmerge[b*8 +: 8] = data[b*8 +: 8];
        end
      end
    end
  endfunction

  // one bit per input from one bit per group of four
  function [15:0] expand_groups;
    input [3:0] grp;
    integer g;
    begin
      expand_groups = 16'h0000;
      for (g = 0; g < 4; g = g + 1) begin
        expand_groups[g*4 +: 4] = {4{grp[g]}};
      end
    end
  endfunction

  // installed-module straps, caught once after reset release
  reg  [3:0]  present;
  reg         strap_done;
  wire [15:0] present_mask = expand_groups(present);

  reg  [7:0]  bounce_filter_interval;
  reg  [15:0] event_enable;
  reg  [31:0] threshold;

  // microsecond time base
  reg  [6:0]  us_div;
  reg  [31:0] time_us;
  reg  [16:0] scan_div;
  wire        scan_tick = (scan_div == SCAN_LAST);

  // per-input debounce state
  reg  [15:0] validated;
  reg  [7:0]  qual_count [0:15];
  reg  [31:0] first_time [0:15];
  reg  [31:0] event_stamp [0:15];
  reg  [15:0] pending;
  reg  [15:0] raw;
  reg  [15:0] set_pending;
  reg  [15:0] clr_pending;

  // one loop index per process, so that no variable has two drivers
  integer i_raw;
  integer i_deb;
  integer i_set;
  integer i_pick;

  always @(posedge aclk) begin
    if (!aresetn) begin
      present    <= 4'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      present    <= module_present;
      strap_done <= 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      us_div   <= 7'h00;
      time_us  <= 32'h0000_0000;
      scan_div <= 17'h00000;
    end else begin
      if (us_div == US_LAST) begin
        us_div  <= 7'h00;
        time_us <= time_us + 32'h0000_0001;
      end else begin
        us_div <= us_div + 7'h01;
      end
      if (scan_tick) begin
        scan_div <= 17'h00000;
      end else begin
        scan_div <= scan_div + 17'h00001;
      end
    end
  end

  // closed when the voltage reaches its group threshold
  always @* begin
    for (i_raw = 0; i_raw < 16; i_raw = i_raw + 1) begin
      raw[i_raw] = (contact_voltage[i_raw*8 +: 8] >= threshold[(i_raw/4)*8 +: 8]) && present_mask[i_raw];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      validated <= 16'h0000;
      for (i_deb = 0; i_deb < 16; i_deb = i_deb + 1) begin
        qual_count[i_deb]  <= 8'h00;
        first_time[i_deb]  <= 32'h0000_0000;
        event_stamp[i_deb] <= 32'h0000_0000;
      end
    end else if (scan_tick) begin
      for (i_deb = 0; i_deb < 16; i_deb = i_deb + 1) begin
        if (raw[i_deb] != validated[i_deb]) begin
          // at or past the interval: a shortened setting must not strand a running count above it
          if (qual_count[i_deb] >= bounce_filter_interval) begin
            validated[i_deb]   <= raw[i_deb];
            qual_count[i_deb]  <= 8'h00;
            event_stamp[i_deb] <= (qual_count[i_deb] == 8'h00) ? time_us : first_time[i_deb];
          end else begin
            if (qual_count[i_deb] == 8'h00) begin
              first_time[i_deb] <= time_us;
            end
            qual_count[i_deb] <= qual_count[i_deb] + 8'h01;
          end
        end else begin
          qual_count[i_deb] <= 8'h00;
        end
      end
    end
  end

  always @* begin
    set_pending = 16'h0000;
    for (i_set = 0; i_set < 16; i_set = i_set + 1) begin
      if (scan_tick && raw[i_set] != validated[i_set] && qual_count[i_set] >= bounce_filter_interval) begin
        set_pending[i_set] = event_enable[i_set];
      end
    end
  end

  // event hand-out, lowest index first
  reg        pick_found;
  reg  [3:0] pick_index;
  always @* begin
    pick_found = 1'b0;
    pick_index = 4'h0;
    for (i_pick = 15; i_pick >= 0; i_pick = i_pick - 1) begin
      if (pending[i_pick]) begin
        pick_found = 1'b1;
        pick_index = i_pick[3:0];
      end
    end
  end

  wire load_event = pick_found && (!event_valid || event_ready);

  always @* begin
    clr_pending = 16'h0000;
    if (load_event) begin
      clr_pending[pick_index] = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pending       <= 16'h0000;
      event_valid   <= 1'b0;
      event_index   <= 4'h0;
      event_closed  <= 1'b0;
      event_time_us <= 32'h0000_0000;
    end else begin
      // a new validation wins over the clear of the same bit
      pending <= (pending & ~clr_pending) | set_pending;
      if (load_event) begin
        event_valid   <= 1'b1;
        event_index   <= pick_index;
        event_closed  <= validated[pick_index];
        event_time_us <= event_stamp[pick_index];
      end else if (event_ready) begin
        event_valid <= 1'b0;
      end
    end
  end

  // flags change only at the start of an evaluation pass
  always @(posedge aclk) begin
    if (!aresetn) begin
      input_closed_flag <= 16'h0000;
    end else if (pass_start) begin
      input_closed_flag <= validated & present_mask;
    end
  end

  // axi4-lite write channel
  reg        aw_held;
  reg        w_held;
  reg [7:0]  wr_addr;
  reg [31:0] wr_data;
  reg [3:0]  wr_strb;
  wire [31:0] thr_mask = {{8{present[3]}}, {8{present[2]}}, {8{present[1]}}, {8{present[0]}}};
  wire [31:0] thr_new  = wmerge(threshold, wr_data, wr_strb);
  wire [31:0] en_new   = wmerge({16'h0000, event_enable}, wr_data, wr_strb);
  wire [31:0] int_new  = wmerge({24'h000000, bounce_filter_interval}, wr_data, wr_strb);
  wire        wr_go    = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready          <= 1'b1;
      s_axi_wready           <= 1'b1;
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= `CID_RESP_OKAY;
      aw_held                <= 1'b0;
      w_held                 <= 1'b0;
      wr_addr                <= 8'h00;
      wr_data                <= 32'h0000_0000;
      wr_strb                <= 4'h0;
      bounce_filter_interval <= `CID_RST_INTERVAL;
      event_enable           <= `CID_RST_EVENT_EN;
      threshold              <= {4{`CID_RST_THRESHOLD}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `CID_RESP_OKAY;
        case ({wr_addr[7:2], 2'b00})
          `CID_OFF_INTERVAL: begin
            bounce_filter_interval <= int_new[7:0];
          end
          `CID_OFF_EVENT_EN: begin
            event_enable <= en_new[15:0] & present_mask;
          end
          `CID_OFF_THRESHOLD: begin
            threshold <= (thr_new & thr_mask) | (threshold & ~thr_mask);
          end
          `CID_OFF_PRESENT, `CID_OFF_VALIDATED, `CID_OFF_CLOSED, `CID_OFF_TIME_US, `CID_OFF_PENDING: begin
            s_axi_bresp <= `CID_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `CID_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  reg [31:0] rd_word;
  reg        rd_err;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    case ({s_axi_araddr[7:2], 2'b00})
      `CID_OFF_INTERVAL:  rd_word = {24'h000000, bounce_filter_interval};
      `CID_OFF_EVENT_EN:  rd_word = {16'h0000, event_enable};
      `CID_OFF_THRESHOLD: rd_word = threshold & thr_mask;
      `CID_OFF_PRESENT:   rd_word = {16'h0000, present_mask};
      `CID_OFF_VALIDATED: rd_word = {16'h0000, validated};
      `CID_OFF_CLOSED:    rd_word = {16'h0000, input_closed_flag};
      `CID_OFF_TIME_US:   rd_word = time_us;
      `CID_OFF_PENDING:   rd_word = {16'h0000, pending};
      default:            rd_err  = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CID_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_err ? `CID_RESP_SLVERR : `CID_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // cid_debouncer
`default_nettype wire

// File: pkg/cid_map.vh
// register offsets, reset values and timing constants of the contact input debouncer
`ifndef CID_MAP_VH
`define CID_MAP_VH

`define CID_NUM_INPUTS      16
`define CID_NUM_GROUPS      4
`define CID_GROUP_SIZE      4

`define CID_OFF_INTERVAL    8'h00
`define CID_OFF_EVENT_EN    8'h04
`define CID_OFF_THRESHOLD   8'h08
`define CID_OFF_PRESENT     8'h0C
`define CID_OFF_VALIDATED   8'h10
`define CID_OFF_CLOSED      8'h14
`define CID_OFF_TIME_US     8'h18
`define CID_OFF_PENDING     8'h1C

`define CID_RST_INTERVAL    8'h04
`define CID_RST_EVENT_EN    16'h0000
`define CID_RST_THRESHOLD   8'h11

`define CID_CLK_MHZ         100
`define CID_SCAN_US         500
`define CID_US_NS           1000
`define CID_CLK_NS          10

`define CID_RESP_OKAY       2'b00
`define CID_RESP_SLVERR     2'b10

`endif
